// *** rtl/align_regs_defines.svh ***
`ifndef ALIGN_REGS_DEFINES_SVH
`define ALIGN_REGS_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_QA_ALIGN     18'h30805
`define IDX_QB_ALIGN     18'h30905
`define IDX_QA_PART      18'h30810
`define IDX_QB_PART      18'h30910
`define IDX_QA_MODE      18'h30811
`define IDX_QB_MODE      18'h30911
`define IDX_QA_FIFO      18'h30814
`define IDX_QB_FIFO      18'h30914
`define IDX_CLKSEL       18'h30a00
`define IDX_THR_LO       18'h30a01
`define IDX_THR_HI       18'h30a02
`define IDX_EIGHT_STAT   18'h30a03
`define IDX_IRQ_STAT     18'h30a10
`define IDX_IRQ_EN       18'h30a11
`define IDX_IRQ_CLR      18'h30a12

// Layout of the synchronised status vector.
`define STAT_W           30
`define ST_WORD          0
`define ST_GROUP         8
`define ST_PAIR_OVFL     16
`define ST_QUAD_OVFL     20
`define ST_PAIR_OOS      22
`define ST_QUAD_OOS      26
`define ST_EIGHT_OVFL    28
`define ST_EIGHT_OOS     29

// Field positions inside the control registers.
`define THR_LO_POS       5
`define THR_HI_W         2
`define RESYNC8_BIT      2
`define PART_POS         4

// Interrupt status bit positions.
`define IRQ_WORD         0
`define IRQ_GROUP        1
`define IRQ_PAIR_OVFL    2
`define IRQ_QUAD_OVFL    3
`define IRQ_PAIR_OOS     4
`define IRQ_QUAD_OOS     5
`define IRQ_EIGHT_OVFL   6
`define IRQ_EIGHT_OOS    7

`define RESET_BYTE       8'h00

`endif

// *** rtl/align_regs_pkg.sv ***
`default_nettype none

package align_regs_pkg;

   // Grouping codes as stored in the field, bit 0 first in printed order.
   typedef enum logic [1:0]
   {
      GROUP_NONE  = 2'h0,
      GROUP_TWIN  = 2'h1,
      GROUP_QUAD  = 2'h2,
      GROUP_EIGHT = 2'h3
   } align_group_type;

   typedef struct packed
   {
      logic [29:0] sync1;
      logic [29:0] sync2;
      logic [29:0] sync3;
      logic [29:0] stat;
      logic [7:0]  clksel;
      logic [2:0]  thr_lo;
      logic [2:0]  ctl_hi;
      logic [7:0]  participate;
      logic [15:0] group_sel;
      logic [7:0]  irq_status;
      logic [7:0]  irq_enable;
      logic        irq;
      logic        resync;
      logic [7:0]  ptr_reset;
      logic        ack;
      logic [31:0] rdata;
   } state_type;

endpackage

`default_nettype wire

// *** rtl/serdes_align_status_ctrl_regs.sv ***
// The Wishbone slave port was chosen for this implementation.
`include "align_regs_defines.svh"
`default_nettype none

module serdes_align_status_ctrl_regs
#(
   parameter int ADR_W = 20
)
(
   input  wire logic                          mclk_i,
   input  wire logic                          reset_i,
   input  wire logic                          ce_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [ADR_W-1:0]              wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic [7:0]                    word_align_done_i,
   input  wire logic [7:0]                    group_align_done_i,
   input  wire logic [3:0]                    pair_fifo_overflow_i,
   input  wire logic [1:0]                    quad_fifo_overflow_i,
   input  wire logic [3:0]                    pair_align_failed_i,
   input  wire logic [1:0]                    quad_align_failed_i,
   input  wire logic                          eight_fifo_overflow_i,
   input  wire logic                          eight_align_failed_i,
   output logic      [1:0]                    quad_a_tx_clk_source_o,
   output logic      [1:0]                    quad_a_rx_clk_source_o,
   output logic      [1:0]                    quad_b_tx_clk_source_o,
   output logic      [1:0]                    quad_b_rx_clk_source_o,
   output logic      [4:0]                    rx_fifo_low_thresh_o,
   output logic      [7:0]                    channel_align_participate_o,
   output align_regs_pkg::align_group_type    align_group_select_o [8],
   output logic                               resync_all_eight_o,
   output logic      [7:0]                    fifo_ptr_reset_o,
   output logic                               irq_o
);
   import align_regs_pkg::*;

   if (ADR_W < 20)
   begin : g_adr_check
      $error("Address bus too narrow for the register map.");
   end

   state_type   st_q;
   state_type   st_d;

   logic [17:0] idx;
   logic        req;
   logic        wr;
   logic [29:0] agree;
   logic [29:0] rise;
   logic [7:0]  ev;
   logic [7:0]  wb;

   assign idx = wb_adr_i[19:2];
   assign wb  = wb_dat_i[7:0];

   // Any rising bit within a slice of the status vector.
   function automatic logic any_rise(input logic [29:0] r, input int pos, input int w);
      logic res;
      res = 1'b0;
      for (int i = 0; i < w; i++)
      begin
         res = res | r[pos + i];
      end
      return res;
   endfunction

   // Status byte of one quad: pair and quad overflow, then pair and quad failure.
   function automatic logic [7:0] fifo_byte(input logic [29:0] s, input int q);
      logic [7:0] res;
      res = 8'h00;
      res[1:0] = s[`ST_PAIR_OVFL + 2 * q +: 2];
      res[2]   = s[`ST_QUAD_OVFL + q];
      res[4:3] = s[`ST_PAIR_OOS + 2 * q +: 2];
      res[5]   = s[`ST_QUAD_OOS + q];
      return res;
   endfunction

   always_comb
   begin
      st_d = st_q;
      req  = wb_cyc_i & wb_stb_i;
      wr   = req & wb_we_i & st_q.ack & wb_sel_i[0];

      // every status bit is synchronised on its own
      st_d.sync1 = {eight_align_failed_i, eight_fifo_overflow_i, quad_align_failed_i,
                    pair_align_failed_i, quad_fifo_overflow_i, pair_fifo_overflow_i,
                    group_align_done_i, word_align_done_i};
      st_d.sync2 = st_q.sync1;
      st_d.sync3 = st_q.sync2;
      agree      = ~(st_q.sync2 ^ st_q.sync3);
      // word and group status follow the channels once stable
      st_d.stat  = (st_q.stat & ~agree) | (st_q.sync3 & agree);
      rise       = st_d.stat & ~st_q.stat;

      ev = 8'h00;
      ev[`IRQ_WORD]       = any_rise(rise, `ST_WORD, 8);
      ev[`IRQ_GROUP]      = any_rise(rise, `ST_GROUP, 8);
      ev[`IRQ_PAIR_OVFL]  = any_rise(rise, `ST_PAIR_OVFL, 4);
      ev[`IRQ_QUAD_OVFL]  = any_rise(rise, `ST_QUAD_OVFL, 2);
      ev[`IRQ_PAIR_OOS]   = any_rise(rise, `ST_PAIR_OOS, 4);
      ev[`IRQ_QUAD_OOS]   = any_rise(rise, `ST_QUAD_OOS, 2);
      ev[`IRQ_EIGHT_OVFL] = rise[`ST_EIGHT_OVFL];
      ev[`IRQ_EIGHT_OOS]  = rise[`ST_EIGHT_OOS];

      if (wr)
      begin
         if (idx == `IDX_CLKSEL)
         begin
            st_d.clksel = wb;
         end
         else if (idx == `IDX_THR_LO)
         begin
            st_d.thr_lo = wb[`THR_LO_POS +: 3];
         end
         else if (idx == `IDX_THR_HI)
         begin
            st_d.ctl_hi = wb[2:0];
         end
         else if (idx == `IDX_QA_PART)
         begin
            st_d.participate[3:0] = wb[`PART_POS +: 4];
         end
         else if (idx == `IDX_QB_PART)
         begin
            st_d.participate[7:4] = wb[`PART_POS +: 4];
         end
         else if (idx == `IDX_QA_MODE)
         begin
            st_d.group_sel[7:0] = wb;
         end
         else if (idx == `IDX_QB_MODE)
         begin
            st_d.group_sel[15:8] = wb;
         end
         else if (idx == `IDX_IRQ_EN)
         begin
            st_d.irq_enable = wb;
         end
      end

      // A new event wins over a clear in the same cycle.
      if (wr && idx == `IDX_IRQ_CLR)
      begin
         st_d.irq_status = (st_q.irq_status & ~wb) | ev;
      end
      else
      begin
         st_d.irq_status = st_q.irq_status | ev;
      end
      st_d.irq = |(st_d.irq_status & st_d.irq_enable);

      // rising edge of the stored bit gives one pulse
      st_d.resync = st_d.ctl_hi[`RESYNC8_BIT] & ~st_q.ctl_hi[`RESYNC8_BIT];
      for (int c = 0; c < 8; c++)
      begin
         // pointers reset for each participating channel in the eight-channel group
         st_d.ptr_reset[c] = st_d.resync & st_d.participate[c] &
                             (st_d.group_sel[2 * c +: 2] == GROUP_EIGHT);
      end

      st_d.ack   = req & ~st_q.ack;
      st_d.rdata = 32'h0000_0000;
      if (req && !st_q.ack && !wb_we_i)
      begin
         if (idx == `IDX_QA_ALIGN)
         begin
            // group status in the upper nibble
            st_d.rdata[7:0] = {st_q.stat[`ST_GROUP +: 4], st_q.stat[`ST_WORD +: 4]};
         end
         else if (idx == `IDX_QB_ALIGN)
         begin
            st_d.rdata[7:0] = {st_q.stat[`ST_GROUP + 4 +: 4], st_q.stat[`ST_WORD + 4 +: 4]};
         end
         else if (idx == `IDX_QA_FIFO)
         begin
            st_d.rdata[7:0] = fifo_byte(st_q.stat, 0);
         end
         else if (idx == `IDX_QB_FIFO)
         begin
            st_d.rdata[7:0] = fifo_byte(st_q.stat, 1);
         end
         else if (idx == `IDX_CLKSEL)
         begin
            st_d.rdata[7:0] = st_q.clksel;
         end
         else if (idx == `IDX_THR_LO)
         begin
            st_d.rdata[7:0] = {st_q.thr_lo, 5'h00};
         end
         else if (idx == `IDX_THR_HI)
         begin
            st_d.rdata[7:0] = {5'h00, st_q.ctl_hi};
         end
         else if (idx == `IDX_EIGHT_STAT)
         begin
            // overflow in bit 0, failure in bit 1
            st_d.rdata[7:0] = {6'h00, st_q.stat[`ST_EIGHT_OOS], st_q.stat[`ST_EIGHT_OVFL]};
         end
         else if (idx == `IDX_QA_PART)
         begin
            st_d.rdata[7:0] = {st_q.participate[3:0], 4'h0};
         end
         else if (idx == `IDX_QB_PART)
         begin
            st_d.rdata[7:0] = {st_q.participate[7:4], 4'h0};
         end
         else if (idx == `IDX_QA_MODE)
         begin
            st_d.rdata[7:0] = st_q.group_sel[7:0];
         end
         else if (idx == `IDX_QB_MODE)
         begin
            st_d.rdata[7:0] = st_q.group_sel[15:8];
         end
         else if (idx == `IDX_IRQ_STAT)
         begin
            st_d.rdata[7:0] = st_q.irq_status;
         end
         else if (idx == `IDX_IRQ_EN)
         begin
            st_d.rdata[7:0] = st_q.irq_enable;
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         st_q <= '0;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
      end
   end

   assign wb_dat_o = st_q.rdata;
   assign wb_ack_o = st_q.ack;
   // field value is the channel index, bit 0 first in printed order
   assign quad_a_tx_clk_source_o = st_q.clksel[1:0];
   assign quad_a_rx_clk_source_o = st_q.clksel[3:2];
   assign quad_b_tx_clk_source_o = st_q.clksel[5:4];
   assign quad_b_rx_clk_source_o = st_q.clksel[7:6];
   // high bits above the low bits
   assign rx_fifo_low_thresh_o   = {st_q.ctl_hi[`THR_HI_W-1:0], st_q.thr_lo};
   assign channel_align_participate_o = st_q.participate;
   for (genvar c = 0; c < 8; c++)
   begin : g_group
      assign align_group_select_o[c] = align_group_type'(st_q.group_sel[2 * c +: 2]);
   end
   assign resync_all_eight_o = st_q.resync;
   assign fifo_ptr_reset_o   = st_q.ptr_reset;
   assign irq_o              = st_q.irq;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle.");

   chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("Request not answered in the next cycle.");

   chk_word_status_track: assert property (($stable(word_align_done_i) && ce_i)[*5] |-> st_q.stat[7:0] == word_align_done_i)
      else $error("Word alignment status does not follow input.");

   chk_group_status_track: assert property (($stable(group_align_done_i) && ce_i)[*5] |-> st_q.stat[15:8] == group_align_done_i)
      else $error("Group alignment status does not follow input.");

   chk_pair_ovfl_track: assert property (($stable(pair_fifo_overflow_i) && ce_i)[*5] |-> st_q.stat[19:16] == pair_fifo_overflow_i)
      else $error("Pair overflow flag does not follow input.");

   chk_eight_ovfl_track: assert property (($stable(eight_fifo_overflow_i) && ce_i)[*5] |-> st_q.stat[28] == eight_fifo_overflow_i)
      else $error("Eight-channel overflow flag does not follow input.");

   chk_tx_src_write: assert property (wr && ce_i && idx == `IDX_CLKSEL |=> quad_a_tx_clk_source_o == $past(wb_dat_i[1:0]) && quad_b_rx_clk_source_o == $past(wb_dat_i[7:6]))
      else $error("Clock source select not taken from the write.");

   chk_thresh_write: assert property (wr && ce_i && idx == `IDX_THR_HI |=> rx_fifo_low_thresh_o[4:3] == $past(wb_dat_i[1:0]))
      else $error("Threshold high bits not taken from the write.");

   chk_resync_rise: assert property (wr && ce_i && idx == `IDX_THR_HI && wb_dat_i[2] && !st_q.ctl_hi[2] |=> resync_all_eight_o)
      else $error("Resync pulse missing after rising write.");

   chk_resync_single: assert property (resync_all_eight_o |=> !resync_all_eight_o)
      else $error("Resync pulse wider than one cycle.");

   chk_ptr_reset_gate: assert property (fifo_ptr_reset_o != 8'h00 |-> resync_all_eight_o && (fifo_ptr_reset_o & ~channel_align_participate_o) == 8'h00)
      else $error("Pointer reset reached a channel not taking part.");

   chk_irq_level: assert property (irq_o == |(st_q.irq_status & st_q.irq_enable))
      else $error("Interrupt output does not match enabled status.");

   chk_quad_ovfl_track: assert property (($stable(quad_fifo_overflow_i) && ce_i)[*5] |-> st_q.stat[21:20] == quad_fifo_overflow_i)
      else $error("Quad overflow flag does not follow input.");

   chk_pair_oos_track: assert property (($stable(pair_align_failed_i) && ce_i)[*5] |-> st_q.stat[25:22] == pair_align_failed_i)
      else $error("Pair failure flag does not follow input.");

   chk_quad_oos_track: assert property (($stable(quad_align_failed_i) && ce_i)[*5] |-> st_q.stat[27:26] == quad_align_failed_i)
      else $error("Quad failure flag does not follow input.");

   chk_eight_oos_track: assert property (($stable(eight_align_failed_i) && ce_i)[*5] |-> st_q.stat[29] == eight_align_failed_i)
      else $error("Eight-channel failure flag does not follow input.");

   chk_rx_src_write: assert property (wr && ce_i && idx == `IDX_CLKSEL |=> quad_a_rx_clk_source_o == $past(wb_dat_i[3:2]) && quad_b_tx_clk_source_o == $past(wb_dat_i[5:4]))
      else $error("Receive clock source not taken from the write.");

   chk_thresh_low: assert property (wr && ce_i && idx == `IDX_THR_LO |=> rx_fifo_low_thresh_o[2:0] == $past(wb_dat_i[7:5]))
      else $error("Threshold low bits not taken from the write.");

   chk_resync_no_repeat: assert property (wr && ce_i && idx == `IDX_THR_HI && st_q.ctl_hi[2] |=> !resync_all_eight_o)
      else $error("Resync pulse without a rising control bit.");

   chk_ptr_reset_member: assert property (resync_all_eight_o && channel_align_participate_o[0] && align_group_select_o[0] == GROUP_EIGHT |-> fifo_ptr_reset_o[0])
      else $error("Pointer reset missing for an eight-channel member.");

   chk_group_sel_write: assert property (wr && ce_i && idx == `IDX_QA_MODE |=> align_group_select_o[0] == $past(wb_dat_i[1:0]))
      else $error("Grouping field not taken from the write.");

   chk_part_write: assert property (wr && ce_i && idx == `IDX_QA_PART |=> channel_align_participate_o[3:0] == $past(wb_dat_i[7:4]))
      else $error("Participation bits not taken from the write.");

   chk_read_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("Read data not zero outside an answer.");

   chk_irq_sticky: assert property (st_q.irq_status[6] && !(wr && idx == `IDX_IRQ_CLR) |=> st_q.irq_status[6])
      else $error("Interrupt status bit lost without a clear.");

   chk_ce_freeze: assert property (!ce_i |=> st_q == $past(st_q))
      else $error("State changed while the clock enable was low.");

   cov_resync: cover property (resync_all_eight_o && fifo_ptr_reset_o != 8'h00);
   cov_irq: cover property ($rose(irq_o));
   cov_read: cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h0000_0000);

endmodule

`default_nettype wire

// *** tb/serdes_align_status_ctrl_regs_tb.sv ***
`include "align_regs_defines.svh"
`default_nettype none

module serdes_align_status_ctrl_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import align_regs_pkg::*;

   logic            mclk_i = 1'b0;
   logic            reset_i = 1'b1;
   logic            ce_i = 1'b1;
   logic            wb_cyc_i = 1'b0;
   logic            wb_stb_i = 1'b0;
   logic            wb_we_i = 1'b0;
   logic [19:0]     wb_adr_i = 20'h00000;
   logic [3:0]      wb_sel_i = 4'h0;
   logic [31:0]     wb_dat_i = 32'h00000000;
   logic [31:0]     wb_dat_o;
   logic            wb_ack_o;
   logic [7:0]      word_align_done_i = 8'h00;
   logic [7:0]      group_align_done_i = 8'h00;
   logic [3:0]      pair_fifo_overflow_i = 4'h0;
   logic [1:0]      quad_fifo_overflow_i = 2'h0;
   logic [3:0]      pair_align_failed_i = 4'h0;
   logic [1:0]      quad_align_failed_i = 2'h0;
   logic            eight_fifo_overflow_i = 1'b0;
   logic            eight_align_failed_i = 1'b0;
   logic [1:0]      quad_a_tx_clk_source_o;
   logic [1:0]      quad_a_rx_clk_source_o;
   logic [1:0]      quad_b_tx_clk_source_o;
   logic [1:0]      quad_b_rx_clk_source_o;
   logic [4:0]      rx_fifo_low_thresh_o;
   logic [7:0]      channel_align_participate_o;
   align_group_type align_group_select_o [8];
   logic            resync_all_eight_o;
   logic [7:0]      fifo_ptr_reset_o;
   logic            irq_o;
   int              failures = 0;
   int              n_compared = 0;
   int              cycles = 0;
   int              n_pulse = 0;
   int              seed = 32'h8992;
   logic [7:0]      ptr_seen = 8'h00;
   logic [7:0]      d;
   logic [17:0]     idx_list [16];

   serdes_align_status_ctrl_regs uut
   (
      .mclk_i, .reset_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .word_align_done_i, .group_align_done_i,
      .pair_fifo_overflow_i, .quad_fifo_overflow_i, .pair_align_failed_i,
      .quad_align_failed_i, .eight_fifo_overflow_i, .eight_align_failed_i,
      .quad_a_tx_clk_source_o, .quad_a_rx_clk_source_o, .quad_b_tx_clk_source_o,
      .quad_b_rx_clk_source_o, .rx_fifo_low_thresh_o, .channel_align_participate_o,
      .align_group_select_o, .resync_all_eight_o, .fifo_ptr_reset_o, .irq_o
   );

   always #5 mclk_i = ~mclk_i;

   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      if (resync_all_eight_o === 1'b1)
      begin
         n_pulse <= n_pulse + 1;
      end
      ptr_seen <= ptr_seen | fifo_ptr_reset_o;
      if (cycles == 20000)
      begin
         failures = failures + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] got);
      n_compared++;
      if (got !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, got);
         failures++;
      end
   endtask

   // Holds the request until ack is seen, takes data, then releases after that edge.
   task automatic xfer(input logic w, input logic [17:0] idx, input logic [7:0] wd,
                       output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hf;
      wb_dat_i <= {24'h000000, wd};
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         failures++;
      end
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(negedge mclk_i);
   endtask

   task automatic wr(input logic [17:0] idx, input logic [7:0] wd);
      logic [7:0] q;
      xfer(1'b1, idx, wd, q);
   endtask

   task automatic rd(input string nm, input logic [17:0] idx, input logic [7:0] e);
      logic [7:0] q;
      xfer(1'b0, idx, 8'h00, q);
      chk(nm, e, q);
   endtask

   task automatic settle();
      repeat (6) @(negedge mclk_i);
   endtask

   function automatic logic [7:0] fifo_exp(input int qd);
      return {2'b00, quad_align_failed_i[qd], pair_align_failed_i[2*qd+:2],
              quad_fifo_overflow_i[qd], pair_fifo_overflow_i[2*qd+:2]};
   endfunction

   initial
   begin
      idx_list = '{`IDX_QA_ALIGN, `IDX_QB_ALIGN, `IDX_QA_PART, `IDX_QB_PART, `IDX_QA_MODE,
                   `IDX_QB_MODE, `IDX_QA_FIFO, `IDX_QB_FIFO, `IDX_CLKSEL, `IDX_THR_LO,
                   `IDX_THR_HI, `IDX_EIGHT_STAT, `IDX_IRQ_STAT, `IDX_IRQ_EN, `IDX_IRQ_CLR,
                   18'h30a20};
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      foreach (idx_list[i])
      begin
         rd("reset value", idx_list[i], 8'h00);
      end
      // Status registers follow the live inputs and ignore writes.
      repeat (4)
      begin
         @(posedge mclk_i);
         {word_align_done_i, group_align_done_i} <= 16'($random(seed));
         {pair_fifo_overflow_i, quad_fifo_overflow_i} <= 6'($random(seed));
         {pair_align_failed_i, quad_align_failed_i} <= 6'($random(seed));
         {eight_fifo_overflow_i, eight_align_failed_i} <= 2'($random(seed));
         settle();
         wr(`IDX_QA_ALIGN, 8'hff);
         rd("align a", `IDX_QA_ALIGN, {group_align_done_i[3:0], word_align_done_i[3:0]});
         rd("align b", `IDX_QB_ALIGN, {group_align_done_i[7:4], word_align_done_i[7:4]});
         rd("fifo a", `IDX_QA_FIFO, fifo_exp(0));
         rd("fifo b", `IDX_QB_FIFO, fifo_exp(1));
         rd("eight", `IDX_EIGHT_STAT, {6'h00, eight_align_failed_i, eight_fifo_overflow_i});
      end
      // Every channel code in every clock select field, then a random byte.
      for (int k = 0; k < 5; k++)
      begin
         d = (k < 4) ? 8'(k * 8'h55) : 8'($random(seed));
         wr(`IDX_CLKSEL, d);
         rd("clksel", `IDX_CLKSEL, d);
         chk("clk sources", d, {quad_b_rx_clk_source_o, quad_b_tx_clk_source_o,
                                quad_a_rx_clk_source_o, quad_a_tx_clk_source_o});
      end
      for (int k = 0; k < 4; k++)
      begin
         d = (k == 0) ? 8'd17 : ((k == 1) ? 8'd31 : 8'($unsigned($random(seed)) % 18));
         wr(`IDX_THR_LO, {d[2:0], 5'h00});
         wr(`IDX_THR_HI, {6'h00, d[4:3]});
         chk("threshold", {3'h0, d[4:0]}, {3'h0, rx_fifo_low_thresh_o});
      end
      // Resync pulse reaches only participating eight-channel members.
      wr(`IDX_QA_PART, 8'h5f);
      wr(`IDX_QB_PART, 8'ha0);
      wr(`IDX_QA_MODE, 8'hff);
      wr(`IDX_QB_MODE, 8'h0f);
      rd("participate a", `IDX_QA_PART, 8'h50);
      chk("participate", 8'ha5, channel_align_participate_o);
      chk("group b a", {6'h00, GROUP_EIGHT}, {6'h00, align_group_select_o[4]});
      chk("group b c", {6'h00, GROUP_NONE}, {6'h00, align_group_select_o[6]});
      n_pulse = 0;
      ptr_seen = 8'h00;
      wr(`IDX_THR_HI, 8'h04);
      wr(`IDX_THR_HI, 8'h04);
      chk("resync pulses", 8'd1, 8'(n_pulse));
      chk("pointer resets", 8'h25, ptr_seen);
      wr(`IDX_THR_HI, 8'h00);
      wr(`IDX_THR_HI, 8'h06);
      @(negedge mclk_i);
      chk("resync again", 8'd2, 8'(n_pulse));
      // Interrupt: raise, mask, stay sticky, clear.
      @(posedge mclk_i);
      {word_align_done_i, eight_fifo_overflow_i} <= 9'h000;
      settle();
      wr(`IDX_IRQ_EN, 8'h00);
      wr(`IDX_IRQ_CLR, 8'hff);
      rd("irq status", `IDX_IRQ_STAT, 8'h00);
      wr(`IDX_IRQ_EN, 8'h41);
      chk("irq idle", 8'h00, {7'h00, irq_o});
      @(posedge mclk_i);
      eight_fifo_overflow_i <= 1'b1;
      settle();
      chk("irq raised", 8'h01, {7'h00, irq_o});
      wr(`IDX_IRQ_EN, 8'h01);
      chk("irq masked", 8'h00, {7'h00, irq_o});
      @(posedge mclk_i);
      eight_fifo_overflow_i <= 1'b0;
      word_align_done_i <= 8'h08;
      settle();
      rd("irq sticky", `IDX_IRQ_STAT, 8'h41);
      chk("irq word", 8'h01, {7'h00, irq_o});
      wr(`IDX_IRQ_CLR, 8'h41);
      rd("irq cleared", `IDX_IRQ_STAT, 8'h00);
      chk("irq low", 8'h00, {7'h00, irq_o});
      print_verdict();
   end
endmodule

`default_nettype wire
